/* File: ntbcr_map.vh */
// register map, field positions and reset values of the bridge endpoint config slice
//
// Contract
// RULE1 - action code 0 masks, 1 sends msi, 2 to 5 send legacy a to d
// RULE2 - an msi goes out only while the msi enable bit is set
// RULE3 - legacy assert or negate messages go out only while legacy disable is clear
// RULE4 - legacy assert when status bit sets, negate when it later clears
// RULE5 - software keeps an action field unchanged while its status bit is set
// RULE6 - doorbell 14:12, far reset 17:15, far power 20:18; 28:21 read zero
// RULE7 - bits 31:29 give the traffic class of every generated msi
// RULE8 - second action register holds port a link-up selector at bits 2:0
// RULE9 - power capability reads id 0x1, next pointer zero, version 0x2 at 18:16
// RULE10 - d1, d2 unsupported and no wake-capable states reported
// RULE11 - special init bit 21 reads zero, writable only when unlocked
// RULE12 - power level field 1:0 reports and accepts d0 and d3hot only
// RULE13 - wake enable, wake status, data select, scale and data read zero
// RULE14 - indirect pointer holds dword number 7:2 and extended number 11:8
// RULE15 - window read returns, window write updates, the pointed register
// RULE16 - window accesses apply the incoming byte enables to the target
// RULE17 - pointer at the window itself: reads zero, writes dropped
// RULE18 - pointer at the pointer: window write changes the pointer
// RULE19 - software never uses the far side pointer or window registers
// RULE20 - extended capability header reads all zero
// RULE21 - bridge configuration word is 32 bit read-write, reset zero
// RULE22 - far reset flag bit 5 sets on far reset, write one clears
// RULE23 - far power change flag bit 6 sets on far power write, write one clears
// RULE24 - port a up flag bit 7 sets on link up transition, write one clears
// RULE25 - reserved action codes behave as masked
// RULE26 - reserved bits read zero and ignore writes, except bridge config word
`ifndef NTBCR_MAP_VH
`define NTBCR_MAP_VH

`define NTBCR_OFS_FLAGS      12'h0e8
`define NTBCR_OFS_ACT0       12'h0ec
`define NTBCR_OFS_PMCAP      12'h0f0
`define NTBCR_OFS_PMCSR      12'h0f4
`define NTBCR_OFS_PTR        12'h0f8
`define NTBCR_OFS_WIN        12'h0fc
`define NTBCR_OFS_EXTCAP     12'h100
`define NTBCR_OFS_BCFG       12'h200
`define NTBCR_OFS_ACT1       12'h210

`define NTBCR_ACT_MASKED     3'h0
`define NTBCR_ACT_MSI        3'h1
`define NTBCR_ACT_INTA       3'h2
`define NTBCR_ACT_INTD       3'h5

`define NTBCR_BIT_DBELL      4
`define NTBCR_BIT_FRST       5
`define NTBCR_BIT_FPWR       6
`define NTBCR_BIT_PAUP       7

`define NTBCR_ACT0_DBELL_LO  12
`define NTBCR_ACT0_FRST_LO   15
`define NTBCR_ACT0_FPWR_LO   18
`define NTBCR_ACT0_TC_LO     29
`define NTBCR_ACT1_PAUP_LO   0

`define NTBCR_PMCAP_ID       8'h01
`define NTBCR_PMCAP_NEXT     8'h00
`define NTBCR_PMCAP_REV      3'h2
`define NTBCR_PMCAP_INIT_BIT 21

`define NTBCR_PWR_D0         2'h0
`define NTBCR_PWR_D3HOT      2'h3

`define NTBCR_RST_WORD       32'h00000000
`define NTBCR_RST_PTR        10'h000

`endif

/* File: ntbcr_evt.v */
// per-event action decoder and message pulse generator
`timescale 1ns/100ps
`include "ntbcr_map.vh"
module ntbcr_evt (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       flag,
    input  wire [2:0] action,
    input  wire       msi_enable,
    input  wire       legacy_irq_disable,
    output reg        msi_q,
    output reg        intx_set_q,
    output reg        intx_clr_q,
    output reg  [1:0] intx_line_q
);
    reg        flag_q;
    reg        asserted_q;
    wire       rise;
    wire       fall;
    wire       is_msi;
    wire       is_intx;

    assign rise = flag & ~flag_q;
    assign fall = ~flag & flag_q;
    // RULE1 RULE25 code decode
    assign is_msi  = (action == `NTBCR_ACT_MSI);
    assign is_intx = (action >= `NTBCR_ACT_INTA) && (action <= `NTBCR_ACT_INTD);

    always @(posedge ref_clk) begin
        if (srst) begin
            flag_q      <= 1'b0;
            asserted_q  <= 1'b0;
            msi_q       <= 1'b0;
            intx_set_q  <= 1'b0;
            intx_clr_q  <= 1'b0;
            intx_line_q <= 2'h0;
        end else begin
            flag_q <= flag;
            // RULE2 msi gated by enable
            msi_q <= rise & is_msi & msi_enable;
            // RULE3 RULE4 legacy assert on set
            intx_set_q <= rise & is_intx & ~legacy_irq_disable;
            // RULE3 RULE4 legacy negate on clear
            intx_clr_q <= fall & asserted_q & is_intx & ~legacy_irq_disable;
            if (rise & is_intx & ~legacy_irq_disable) begin
                asserted_q <= 1'b1;
            end else if (fall) begin
                asserted_q <= 1'b0;
            end
            if (is_intx) begin
                intx_line_q <= action[1:0] - 2'h2;
            end
        end
    end
endmodule // ntbcr_evt

/* File: ntbcr_regs.v */
// configuration register slice of the bridge endpoint with event message generation
`timescale 1ns/100ps
`include "ntbcr_map.vh"
module ntbcr_regs (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        cfg_req,
    input  wire        cfg_wr,
    input  wire [11:2] cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg         cfg_ack_q,
    output reg  [31:0] cfg_rdata_q,
    input  wire        inbound_ring_flag,
    input  wire        far_reset_pulse,
    input  wire        far_power_write_pulse,
    input  wire        port_a_dl_up,
    input  wire        msi_enable,
    input  wire        legacy_irq_disable,
    input  wire        init_flag_unlock,
    output reg  [7:0]  event_flags_q,
    output reg  [1:0]  power_level_field_q,
    output reg  [31:0] bridge_config_q,
    output reg  [2:0]  msi_class_field_q,
    output reg  [3:0]  evt_msi_q,
    output reg  [3:0]  evt_intx_set_q,
    output reg  [3:0]  evt_intx_clr_q,
    output reg  [7:0]  evt_intx_line_q
);
    reg  [31:0] act0_q;
    reg  [2:0]  act1_q;
    reg         init_flag_q;
    reg  [1:0]  pwr_q;
    reg  [9:0]  ptr_q;
    reg  [31:0] bcfg_q;
    reg         far_reset_seen_q;
    reg         far_side_power_change_q;
    reg         port_a_up_flag_q;
    reg         dl_up_q;
    reg  [11:0] eff_addr;
    reg         win_self;
    reg  [31:0] rd_word;
    reg  [31:0] wmask;
    reg  [31:0] merged;
    wire        acc_wr;
    wire        win_sel;
    wire [3:0]  flag_vec;
    wire [11:0] act_vec;
    wire [3:0]  msi_w;
    wire [3:0]  set_w;
    wire [3:0]  clr_w;
    wire [7:0]  line_w;
    wire [7:0]  flags_rd;
    wire        link_rise;

    assign win_sel = ({cfg_addr, 2'b00} == `NTBCR_OFS_WIN);
    assign acc_wr  = cfg_req & cfg_wr;

    // RULE15 RULE17 window redirects to pointed register
    always @* begin
        if (win_sel) begin
            eff_addr = {ptr_q, 2'b00};
        end else begin
            eff_addr = {cfg_addr, 2'b00};
        end
        win_self = win_sel && (eff_addr == `NTBCR_OFS_WIN);
    end

    // RULE16 byte enables apply to direct and window accesses
    always @* begin
        wmask  = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
        merged = (rd_word & ~wmask) | (cfg_wdata & wmask);
    end

    assign flags_rd = {port_a_up_flag_q, far_side_power_change_q, far_reset_seen_q,
                       inbound_ring_flag, 4'h0};

    // read decode of the effective target
    always @* begin
        rd_word = 32'h00000000;
        case (eff_addr)
            `NTBCR_OFS_FLAGS: begin
                rd_word = {24'h000000, flags_rd};
            end
            `NTBCR_OFS_ACT0: begin
                // RULE6 RULE26 reserved bits read zero
                rd_word = {act0_q[31:29], 8'h00, act0_q[20:12], 12'h000};
            end
            `NTBCR_OFS_PMCAP: begin
                // RULE9 RULE10 RULE11 capability word, fixed except init flag bit 21
                rd_word = {5'h00, 1'b0, 1'b0, 3'h0, init_flag_q, 1'b0, 1'b0,
                           `NTBCR_PMCAP_REV, `NTBCR_PMCAP_NEXT, `NTBCR_PMCAP_ID};
            end
            `NTBCR_OFS_PMCSR: begin
                // RULE12 RULE13 only power level visible
                rd_word = {30'h00000000, pwr_q};
            end
            `NTBCR_OFS_PTR: begin
                // RULE14 pointer fields
                rd_word = {20'h00000, ptr_q, 2'b00};
            end
            `NTBCR_OFS_EXTCAP: begin
                // RULE20 empty extended capability
                rd_word = 32'h00000000;
            end
            `NTBCR_OFS_BCFG: begin
                rd_word = bcfg_q;
            end
            `NTBCR_OFS_ACT1: begin
                // RULE8 link-up selector
                rd_word = {29'h00000000, act1_q};
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
        if (win_self) begin
            rd_word = 32'h00000000;
        end
    end

    // bus answer one cycle after the request
    always @(posedge ref_clk) begin
        if (srst) begin
            cfg_ack_q   <= 1'b0;
            cfg_rdata_q <= `NTBCR_RST_WORD;
        end else begin
            cfg_ack_q <= cfg_req;
            if (cfg_req & ~cfg_wr) begin
                // RULE17 self-pointing window reads zero
                cfg_rdata_q <= rd_word;
            end
        end
    end

    // writable registers
    always @(posedge ref_clk) begin
        if (srst) begin
            act0_q      <= `NTBCR_RST_WORD;
            act1_q      <= 3'h0;
            init_flag_q <= 1'b0;
            pwr_q       <= `NTBCR_PWR_D0;
            ptr_q       <= `NTBCR_RST_PTR;
            bcfg_q      <= `NTBCR_RST_WORD;
        end else if (acc_wr && !win_self) begin
            case (eff_addr)
                `NTBCR_OFS_ACT0: begin
                    // RULE6 RULE7 selectors and traffic class
                    act0_q[31:29] <= merged[31:29];
                    act0_q[20:12] <= merged[20:12];
                end
                `NTBCR_OFS_PMCAP: begin
                    // RULE11 lock-guarded special init flag
                    if (init_flag_unlock) begin
                        init_flag_q <= merged[`NTBCR_PMCAP_INIT_BIT];
                    end
                end
                `NTBCR_OFS_PMCSR: begin
                    // RULE12 d1 and d2 codes refused
                    if (merged[1:0] == `NTBCR_PWR_D0 || merged[1:0] == `NTBCR_PWR_D3HOT) begin
                        pwr_q <= merged[1:0];
                    end
                end
                `NTBCR_OFS_PTR: begin
                    // RULE14 RULE18 pointer written directly or through window
                    ptr_q <= merged[11:2];
                end
                `NTBCR_OFS_BCFG: begin
                    // RULE21 RULE26 full read-write word
                    bcfg_q <= merged;
                end
                `NTBCR_OFS_ACT1: begin
                    // RULE8 link-up selector
                    act1_q <= merged[2:0];
                end
                default: begin
                    pwr_q <= pwr_q;
                end
            endcase
        end
    end

    assign link_rise = port_a_dl_up & ~dl_up_q;

    // sticky event flags, set wins over write-one clear
    always @(posedge ref_clk) begin
        if (srst) begin
            far_reset_seen_q        <= 1'b0;
            far_side_power_change_q <= 1'b0;
            port_a_up_flag_q        <= 1'b0;
            dl_up_q                 <= 1'b0;
        end else begin
            dl_up_q <= port_a_dl_up;
            // RULE22 far reset flag
            if (far_reset_pulse) begin
                far_reset_seen_q <= 1'b1;
            end else if (acc_wr && !win_self && eff_addr == `NTBCR_OFS_FLAGS &&
                         wmask[`NTBCR_BIT_FRST] && cfg_wdata[`NTBCR_BIT_FRST]) begin
                far_reset_seen_q <= 1'b0;
            end
            // RULE23 far power change flag
            if (far_power_write_pulse) begin
                far_side_power_change_q <= 1'b1;
            end else if (acc_wr && !win_self && eff_addr == `NTBCR_OFS_FLAGS &&
                         wmask[`NTBCR_BIT_FPWR] && cfg_wdata[`NTBCR_BIT_FPWR]) begin
                far_side_power_change_q <= 1'b0;
            end
            // RULE24 port a link-up flag
            if (link_rise) begin
                port_a_up_flag_q <= 1'b1;
            end else if (acc_wr && !win_self && eff_addr == `NTBCR_OFS_FLAGS &&
                         wmask[`NTBCR_BIT_PAUP] && cfg_wdata[`NTBCR_BIT_PAUP]) begin
                port_a_up_flag_q <= 1'b0;
            end
        end
    end

    assign flag_vec = flags_rd[7:4];
    assign act_vec  = {act1_q, act0_q[20:12]};

    // per-event message generation
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_evt
            // RULE1 RULE2 RULE3 RULE4 RULE25 event action
            ntbcr_evt u_evt (
                .ref_clk            (ref_clk),
                .srst               (srst),
                .flag               (flag_vec[gi]),
                .action             (act_vec[3*gi+2:3*gi]),
                .msi_enable         (msi_enable),
                .legacy_irq_disable (legacy_irq_disable),
                .msi_q              (msi_w[gi]),
                .intx_set_q         (set_w[gi]),
                .intx_clr_q         (clr_w[gi]),
                .intx_line_q        (line_w[2*gi+1:2*gi])
            );
        end
    endgenerate

    // registered outputs
    always @(posedge ref_clk) begin
        if (srst) begin
            event_flags_q       <= 8'h00;
            power_level_field_q <= `NTBCR_PWR_D0;
            bridge_config_q     <= `NTBCR_RST_WORD;
            msi_class_field_q   <= 3'h0;
            evt_msi_q           <= 4'h0;
            evt_intx_set_q      <= 4'h0;
            evt_intx_clr_q      <= 4'h0;
            evt_intx_line_q     <= 8'h00;
        end else begin
            event_flags_q       <= flags_rd;
            power_level_field_q <= pwr_q;
            bridge_config_q     <= bcfg_q;
            // RULE7 class carried with each msi
            msi_class_field_q   <= act0_q[31:29];
            evt_msi_q           <= msi_w;
            evt_intx_set_q      <= set_w;
            evt_intx_clr_q      <= clr_w;
            evt_intx_line_q     <= line_w;
        end
    end
endmodule // ntbcr_regs

/* File: ntbcr_regs_assertions.sv */
// assertion checker bound to the config slice
`timescale 1ns/100ps
`include "ntbcr_map.vh"
module ntbcr_regs_chk (
    input wire        ref_clk,
    input wire        srst,
    input wire        cfg_req,
    input wire        cfg_wr,
    input wire [11:2] cfg_addr,
    input wire [3:0]  cfg_be,
    input wire [31:0] cfg_wdata,
    input wire        cfg_ack_q,
    input wire [31:0] cfg_rdata_q,
    input wire        far_reset_pulse,
    input wire        port_a_dl_up,
    input wire        msi_enable,
    input wire        legacy_irq_disable,
    input wire [7:0]  event_flags_q,
    input wire [1:0]  power_level_field_q,
    input wire [31:0] bridge_config_q,
    input wire [3:0]  evt_msi_q,
    input wire [3:0]  evt_intx_set_q,
    input wire [3:0]  evt_intx_clr_q
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (srst);
wire        rd = cfg_req && !cfg_wr;
wire        wt = cfg_req && cfg_wr;
wire [11:0] ba = {cfg_addr, 2'b00};
property p_ack; cfg_req |=> cfg_ack_q; endproperty
a_ack: assert property (p_ack) else $error("no answer after request");
property p_bcfg; wt && ba == `NTBCR_OFS_BCFG && cfg_be == 4'hf |=> ##1 bridge_config_q == $past(cfg_wdata, 2);
endproperty
a_bcfg: assert property (p_bcfg) else $error("bridge word not stored");
property p_pmcap; rd && ba == `NTBCR_OFS_PMCAP |=> (cfg_rdata_q & 32'hffdfffff) == 32'h00020001; endproperty
a_pmcap: assert property (p_pmcap) else $error("power capability wrong");
property p_pmcsr; rd && ba == `NTBCR_OFS_PMCSR |=> cfg_rdata_q[31:2] == 30'h0; endproperty
a_pmcsr: assert property (p_pmcsr) else $error("power control fixed bits set");
property p_ext; rd && ba == `NTBCR_OFS_EXTCAP |=> cfg_rdata_q == 32'h0; endproperty
a_ext: assert property (p_ext) else $error("extended header not zero");
property p_plev; wt && ba == `NTBCR_OFS_PMCSR && cfg_be[0] && cfg_wdata[1:0] == 2'h3
    |=> ##1 power_level_field_q == 2'h3; endproperty
a_plev: assert property (p_plev) else $error("power level not accepted");
property p_msi; (!msi_enable) [*4] |-> evt_msi_q == 4'h0; endproperty
a_msi: assert property (p_msi) else $error("msi while disabled");
property p_intx; legacy_irq_disable [*4] |-> (evt_intx_set_q | evt_intx_clr_q) == 4'h0; endproperty
a_intx: assert property (p_intx) else $error("legacy message while disabled");
property p_frst; far_reset_pulse |-> ##[1:3] event_flags_q[5]; endproperty
a_frst: assert property (p_frst) else $error("far reset flag not set");
property p_paup; $rose(port_a_dl_up) |-> ##[1:4] event_flags_q[7]; endproperty
a_paup: assert property (p_paup) else $error("link up flag not set");
endmodule // ntbcr_regs_chk
bind ntbcr_regs ntbcr_regs_chk u_chk (.ref_clk(ref_clk), .srst(srst), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q),
    .far_reset_pulse(far_reset_pulse), .port_a_dl_up(port_a_dl_up), .msi_enable(msi_enable),
    .legacy_irq_disable(legacy_irq_disable), .event_flags_q(event_flags_q), .power_level_field_q(power_level_field_q),
    .bridge_config_q(bridge_config_q), .evt_msi_q(evt_msi_q), .evt_intx_set_q(evt_intx_set_q),
    .evt_intx_clr_q(evt_intx_clr_q));

/* File: ntbcr_host.sv */
// host model issuing configuration requests
`timescale 1ns/100ps
module ntbcr_host (
    input  wire        ref_clk,
    input  wire        cfg_ack_q,
    input  wire [31:0] cfg_rdata_q,
    output reg         cfg_req,
    output reg         cfg_wr,
    output reg  [11:2] cfg_addr,
    output reg  [3:0]  cfg_be,
    output reg  [31:0] cfg_wdata
);
reg tmo;
initial begin
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 10'h0;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    tmo = 1'b0;
end
task xfer(input w, input [11:0] a, input [3:0] b, input [31:0] d, output [31:0] q);
    integer i;
    begin
        tmo = 1'b1;
        q = 32'h0;
        cfg_req = 1'b1;
        cfg_wr = w;
        cfg_addr = a[11:2];
        cfg_be = b;
        cfg_wdata = d;
        @(posedge ref_clk);
        #1;
        cfg_req = 1'b0;
        cfg_wr = ~w;
        cfg_addr = ~a[11:2];
        cfg_be = ~b;
        cfg_wdata = ~d;
        for (i = 0; i < 4 && tmo; i = i + 1) begin
            @(posedge ref_clk);
            if (cfg_ack_q === 1'b1) begin
                q = cfg_rdata_q;
                tmo = 1'b0;
            end
        end
        #1;
    end
endtask
endmodule // ntbcr_host

/* File: ntbcr_regs_tb.sv */
// self-checking bench for the config slice
`timescale 1ns/100ps
`include "ntbcr_map.vh"
module ntbcr_regs_tb;
reg ref_clk = 1'b0;
reg srst = 1'b1;
reg ring = 0, frst = 0, fpwr = 0, paup = 0, men = 0, ldis = 0, unl = 0;
wire req, cwr, ack;
wire [11:2] ad;
wire [3:0] be, emsi, eset, eclr;
wire [31:0] wd, rdq, bcq;
wire [7:0] flg, eline;
wire [1:0] plev;
wire [2:0] tc;
integer err_total = 0, checks_done = 0, n_msi = 0, n_set = 0, n_clr = 0;
reg [31:0] q;
always #50 ref_clk = ~ref_clk;
always @(posedge ref_clk) begin
    n_msi <= n_msi + emsi[1] + emsi[3];
    n_set <= n_set + eset[1];
    n_clr <= n_clr + eclr[1];
end
ntbcr_host host (.ref_clk(ref_clk), .cfg_ack_q(ack), .cfg_rdata_q(rdq), .cfg_req(req), .cfg_wr(cwr),
    .cfg_addr(ad), .cfg_be(be), .cfg_wdata(wd));
ntbcr_regs dut (.ref_clk(ref_clk), .srst(srst), .cfg_req(req), .cfg_wr(cwr), .cfg_addr(ad), .cfg_be(be),
    .cfg_wdata(wd), .cfg_ack_q(ack), .cfg_rdata_q(rdq), .inbound_ring_flag(ring), .far_reset_pulse(frst),
    .far_power_write_pulse(fpwr), .port_a_dl_up(paup), .msi_enable(men), .legacy_irq_disable(ldis),
    .init_flag_unlock(unl), .event_flags_q(flg), .power_level_field_q(plev), .bridge_config_q(bcq),
    .msi_class_field_q(tc), .evt_msi_q(emsi), .evt_intx_set_q(eset), .evt_intx_clr_q(eclr), .evt_intx_line_q(eline));
task summarize;
    begin
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
endtask
task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        checks_done = checks_done + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    end
endtask
task xf(input w, input [11:0] a, input [3:0] b, input [31:0] d);
    begin
        host.xfer(w, a, b, d, q);
        if (host.tmo) begin
            err_total = err_total + 1;
            summarize;
        end
    end
endtask
task wr(input [11:0] a, input [3:0] b, input [31:0] d);
    xf(1'b1, a, b, d);
endtask
task rc(input [11:0] a, input [31:0] e, input string nm);
    begin
        xf(1'b0, a, 4'hf, 32'h0);
        chk(nm, e, q);
    end
endtask
task wt(input integer n);
    begin
        repeat (n) @(posedge ref_clk);
        #1;
    end
endtask
task t_rst;
    begin
        rc(`NTBCR_OFS_PMCAP, 32'h00020001, "pmcap");
        rc(`NTBCR_OFS_PMCSR, 32'h0, "pmcsr");
        rc(`NTBCR_OFS_PTR, 32'h0, "ptr");
        rc(`NTBCR_OFS_EXTCAP, 32'h0, "extcap");
        rc(`NTBCR_OFS_BCFG, 32'h0, "bcfg");
        rc(`NTBCR_OFS_ACT1, 32'h0, "act1");
    end
endtask
task t_regs;
    begin
        wr(`NTBCR_OFS_BCFG, 4'hf, 32'hffffffff);
        wr(`NTBCR_OFS_BCFG, 4'h5, 32'h0);
        rc(`NTBCR_OFS_BCFG, 32'hff00ff00, "bcfg");
        chk("bcq", 32'hff00ff00, bcq);
        wr(`NTBCR_OFS_PMCSR, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_PMCSR, 32'h3, "pmcsr");
        wr(`NTBCR_OFS_PMCSR, 4'hf, 32'h1);
        chk("plev", 32'h3, plev);
        wr(`NTBCR_OFS_PMCSR, 4'hf, 32'h0);
        chk("plev", 32'h0, plev);
        wr(`NTBCR_OFS_PTR, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_PTR, 32'hffc, "ptr");
        wr(`NTBCR_OFS_PMCAP, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_PMCAP, 32'h00020001, "pmcap");
        unl = 1;
        wr(`NTBCR_OFS_PMCAP, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_PMCAP, 32'h00220001, "pmcap");
        wr(`NTBCR_OFS_PMCAP, 4'hf, 32'h0);
        wr(`NTBCR_OFS_ACT0, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_ACT0, 32'he01ff000, "act0");
        chk("tc", 32'h7, tc);
        wr(`NTBCR_OFS_ACT0, 4'hf, 32'h0);
        wr(`NTBCR_OFS_ACT1, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_ACT1, 32'h7, "act1");
        wr(`NTBCR_OFS_EXTCAP, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_EXTCAP, 32'h0, "extcap");
        wr(12'h300, 4'hf, 32'hffffffff);
        rc(12'h300, 32'h0, "unmapped");
    end
endtask
task t_win;
    begin
        wr(`NTBCR_OFS_PTR, 4'hf, 32'h200);
        wr(`NTBCR_OFS_WIN, 4'h3, 32'h1234abcd);
        rc(`NTBCR_OFS_BCFG, 32'hff00abcd, "winwr");
        rc(`NTBCR_OFS_WIN, 32'hff00abcd, "winrd");
        wr(`NTBCR_OFS_PTR, 4'hf, 32'h0fc);
        wr(`NTBCR_OFS_WIN, 4'hf, 32'hffffffff);
        rc(`NTBCR_OFS_WIN, 32'h0, "winself");
        rc(`NTBCR_OFS_PTR, 32'h0fc, "ptrkeep");
        wr(`NTBCR_OFS_PTR, 4'hf, 32'h0f8);
        wr(`NTBCR_OFS_WIN, 4'hf, 32'h200);
        rc(`NTBCR_OFS_PTR, 32'h200, "ptrwin");
    end
endtask
task t_ev(input [2:0] c, input m, input d);
    reg lg;
    begin
        lg = c >= 3'h2 && c <= 3'h5 && !d;
        men = m;
        ldis = d;
        wr(`NTBCR_OFS_ACT0, 4'hf, {14'h0, c, 15'h0});
        n_msi = 0;
        n_set = 0;
        n_clr = 0;
        frst = 1;
        wt(1);
        frst = 0;
        wt(5);
        chk("msi", c == 3'h1 && m, n_msi);
        chk("set", lg, n_set);
        if (lg)
            chk("line", c - 3'h2, eline[3:2]);
        rc(`NTBCR_OFS_FLAGS, 32'h20, "flgset");
        wr(`NTBCR_OFS_FLAGS, 4'h1, 32'h20);
        wt(5);
        chk("clr", lg, n_clr);
        rc(`NTBCR_OFS_FLAGS, 32'h0, "flgclr");
    end
endtask
task t_misc;
    begin
        wr(`NTBCR_OFS_ACT1, 4'hf, 32'h1);
        men = 1;
        n_msi = 0;
        paup = 1;
        wt(6);
        chk("pamsi", 32'h1, n_msi);
        rc(`NTBCR_OFS_FLAGS, 32'h80, "paup");
        wr(`NTBCR_OFS_FLAGS, 4'h1, 32'h80);
        fpwr = 1;
        wt(1);
        fpwr = 0;
        wt(4);
        rc(`NTBCR_OFS_FLAGS, 32'h40, "fpwr");
        wr(`NTBCR_OFS_FLAGS, 4'h1, 32'h40);
        ring = 1;
        wr(`NTBCR_OFS_FLAGS, 4'h1, 32'h10);
        rc(`NTBCR_OFS_FLAGS, 32'h10, "ring");
        chk("flg", 32'h10, flg);
    end
endtask
task t_rerst;
    begin
        paup = 0;
        ring = 0;
        srst = 1;
        wt(2);
        srst = 0;
        chk("flg", 32'h0, flg);
        chk("plev", 32'h0, plev);
        chk("bcq", 32'h0, bcq);
        t_rst;
    end
endtask
initial begin : main
    integer k;
    wt(12);
    srst = 0;
    t_rst;
    t_regs;
    t_win;
    for (k = 0; k < 8; k = k + 1)
        t_ev(k[2:0], 1'b1, 1'b0);
    t_ev(3'h1, 1'b0, 1'b0);
    t_ev(3'h2, 1'b1, 1'b1);
    t_misc;
    t_rerst;
    summarize;
end
endmodule // ntbcr_regs_tb
